// >>> core/vprot_map.svh
// Offsets, field positions, reset values and timing counts of the voltage element.
// Assumes a 20 MHz system clock and 32-bit APB data.
`ifndef VPROT_MAP_SVH
`define VPROT_MAP_SVH

// ==========================================================
// Register byte offsets
`define REG_CTRL        8'h00
`define REG_THRESH      8'h04
`define REG_DROPOUT     8'h08
`define REG_TRIP_DLY    8'h0C
`define REG_IMIN_THR    8'h10
`define REG_IMIN_DLY    8'h14
`define REG_VT_SEC      8'h18
`define REG_STATUS      8'h1C
`define REG_INT_STAT    8'h20
`define REG_INT_MASK    8'h24

// ==========================================================
// Control field positions
`define CTRL_ENABLE     0
`define CTRL_UNDER      1
`define CTRL_METHOD_LO  2
`define CTRL_MEAS_PP    4
`define CTRL_CONN_PP    5
`define CTRL_RULE_LO    6
`define CTRL_IMIN_EN    8
`define CTRL_SUPERV_EN  9
`define CTRL_LOP_EN     10
`define CTRL_WIDTH      11

// Interrupt bits
`define INT_PICKUP      0
`define INT_TRIP        1
`define INT_BLOCK       2

// ==========================================================
// Reset values
`define CTRL_RST        11'h000
`define THRESH_RST      16'h1000
`define DROPOUT_RST     16'h0FC0
`define TRIP_DLY_RST    16'h0064
`define IMIN_THR_RST    16'h0000
`define IMIN_DLY_RST    16'h0000
`define VT_SEC_RST      16'h0000

// ==========================================================
// Fixed-point scaling: settings are per-unit with 12 fraction bits
`define PU_SHIFT        12
`define INV_SQRT3_Q15   16'h49E7
`define LOP_LEVEL_PU    16'h007B

// ==========================================================
// Timing
`define CLK_NS          50
`define MS_NS           1000000
`define MS_CYCLES       (`MS_NS / `CLK_NS)
`define AVG_WINDOW_S    600
`define AVG_SEGMENTS    8
`define AVG_SEG_SAMPLES 256
`define CLK_HZ          20000000
`define AVG_SAMPLE_CYCLES \
   (64'd`AVG_WINDOW_S * 64'd`CLK_HZ / (64'd`AVG_SEGMENTS * 64'd`AVG_SEG_SAMPLES))

`endif

// >>> core/vprot_pkg.sv
// Types shared by the voltage protection element.
// Assumes vprot_map.svh is on the include path.
package vprot_pkg;

   // Which measured quantity is compared against the thresholds
   typedef enum logic [1:0] {
      METHOD_FUND,
      METHOD_RMS,
      METHOD_AVG,
      METHOD_RSVD
   } meas_method_t;

   // How many phases must be picked up for the element to pick up
   typedef enum logic [1:0] {
      RULE_ONE_OF_THREE,
      RULE_TWO_OF_THREE,
      RULE_ALL_THREE,
      RULE_RSVD
   } pickup_rule_t;

   typedef enum logic {
      MODE_OVER,
      MODE_UNDER
   } element_mode_t;

endpackage : vprot_pkg

// >>> core/voltage_protection_element.sv
// Three-phase over/undervoltage protection element with APB register access.
// Assumes voltage and current magnitudes come from logic on i_mclk; the
// blocking inputs come from pins and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "vprot_map.svh"

module voltage_protection_element #(
   parameter int unsigned MS_CYCLES         = `MS_CYCLES,
   parameter int unsigned AVG_SAMPLE_CYCLES = 32'(`AVG_SAMPLE_CYCLES)
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic [15:0] i_volt_fund_1,
   input  wire logic [15:0] i_volt_fund_2,
   input  wire logic [15:0] i_volt_fund_3,
   input  wire logic [15:0] i_volt_rms_1,
   input  wire logic [15:0] i_volt_rms_2,
   input  wire logic [15:0] i_volt_rms_3,
   input  wire logic [15:0] i_curr_1,
   input  wire logic [15:0] i_curr_2,
   input  wire logic [15:0] i_curr_3,
   input  wire logic        i_ext_block,
   input  wire logic        i_vt_fuse_fail,
   output logic      [2:0]  o_phase_pickup_flag,
   output logic      [2:0]  o_phase_trip_flag,
   output logic             o_pickup,
   output logic             o_trip,
   output logic             o_irq
);
   import vprot_pkg::*;

   // ==========================================================
   // Registers
   logic [`CTRL_WIDTH-1:0] ctrl_r;
   logic [15:0]            thresh_r;
   logic [15:0]            dropout_r;
   logic [15:0]            trip_dly_r;
   logic [15:0]            imin_thr_r;
   logic [15:0]            imin_dly_r;
   logic [15:0]            vt_sec_r;
   logic [2:0]             int_stat_r;
   logic [2:0]             int_mask_r;

   element_mode_t mode;
   meas_method_t  method;
   pickup_rule_t  rule;
   logic          enable;
   logic          conn_pp;
   logic          meas_pp;

   assign enable  = ctrl_r[`CTRL_ENABLE];
   assign mode    = element_mode_t'(ctrl_r[`CTRL_UNDER]);
   assign method  = meas_method_t'(ctrl_r[`CTRL_METHOD_LO +: 2]);
   assign rule    = pickup_rule_t'(ctrl_r[`CTRL_RULE_LO +: 2]);
   assign conn_pp = ctrl_r[`CTRL_CONN_PP];
   assign meas_pp = ctrl_r[`CTRL_MEAS_PP] | conn_pp;

   // ==========================================================
   // Pin synchronisers
   logic [1:0] ext_sync_r;
   logic [1:0] fuse_sync_r;

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         ext_sync_r  <= 2'h0;
         fuse_sync_r <= 2'h0;
      end else begin
         ext_sync_r  <= {ext_sync_r[0], i_ext_block};
         fuse_sync_r <= {fuse_sync_r[0], i_vt_fuse_fail};
      end
   end

   // ==========================================================
   // Millisecond tick for the delay timers
   logic [31:0] ms_cnt_r;
   logic        ms_tick;

   assign ms_tick = (ms_cnt_r == MS_CYCLES - 1);

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) ms_cnt_r <= 32'h0;
      else if (ms_tick) ms_cnt_r <= 32'h0;
      else ms_cnt_r <= ms_cnt_r + 32'h1;
   end

   // ==========================================================
   // Sliding average of the RMS voltage
   // Window split into segments so only a few words are stored; the
   // average moves one segment at a time, not per sample.
   logic [15:0] v_rms     [3];
   logic [15:0] v_fund    [3];
   logic [23:0] acc_r     [3];
   logic [15:0] seg_r     [`AVG_SEGMENTS][3];
   logic [18:0] win_sum_r [3];
   logic [31:0] smp_cnt_r;
   logic [7:0]  seg_fill_r;
   logic [2:0]  seg_idx_r;
   logic        smp_tick;

   assign v_rms  = '{i_volt_rms_1, i_volt_rms_2, i_volt_rms_3};
   assign v_fund = '{i_volt_fund_1, i_volt_fund_2, i_volt_fund_3};
   assign smp_tick = (smp_cnt_r == AVG_SAMPLE_CYCLES - 1);

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) smp_cnt_r <= 32'h0;
      else if (smp_tick) smp_cnt_r <= 32'h0;
      else smp_cnt_r <= smp_cnt_r + 32'h1;
   end

   always_ff @(posedge i_mclk) begin
      logic [23:0] full;
      full = 24'h0;
      if (!i_rstn) begin
         seg_fill_r <= 8'h0;
         seg_idx_r  <= 3'h0;
         for (int p = 0; p < 3; p++) begin
            acc_r[p]     <= 24'h0;
            win_sum_r[p] <= 19'h0;
            for (int s = 0; s < `AVG_SEGMENTS; s++) seg_r[s][p] <= 16'h0;
         end
      end else if (smp_tick) begin
         seg_fill_r <= seg_fill_r + 8'h1;
         if (seg_fill_r == 8'hFF) seg_idx_r <= seg_idx_r + 3'h1;
         for (int p = 0; p < 3; p++) begin
            full = acc_r[p] + {8'h0, v_rms[p]};
            if (seg_fill_r == 8'hFF) begin
               acc_r[p]            <= 24'h0;
               seg_r[seg_idx_r][p] <= full[23:8];
               win_sum_r[p]        <= win_sum_r[p] + {3'h0, full[23:8]}
                                      - {3'h0, seg_r[seg_idx_r][p]};
            end else begin
               acc_r[p] <= full;
            end
         end
      end
   end

   // ==========================================================
   // Measured quantity and nominal-based thresholds
   logic [23:0] v_sel [3];
   logic [15:0] vn;
   logic [31:0] vn_prod;
   logic [31:0] thr_prod;
   logic [23:0] thr_abs;
   logic [39:0] drop_prod;
   logic [23:0] drop_abs;
   logic [31:0] lop_prod;
   logic [23:0] lop_abs;

   always_comb begin
      for (int p = 0; p < 3; p++) begin
         case (method)
            METHOD_FUND: v_sel[p] = {8'h0, v_fund[p]};
            METHOD_RMS:  v_sel[p] = {8'h0, v_rms[p]};
            METHOD_AVG:  v_sel[p] = {8'h0, win_sum_r[p][18:3]};
            default:     v_sel[p] = {8'h0, v_fund[p]};
         endcase
      end
   end

   assign vn_prod   = vt_sec_r * `INV_SQRT3_Q15;
   assign vn        = meas_pp ? vt_sec_r : vn_prod[30:15];
   assign thr_prod  = vn * thresh_r;
   assign thr_abs   = {4'h0, thr_prod[31:`PU_SHIFT]};
   assign drop_prod = {16'h0, thr_abs} * {24'h0, dropout_r};
   assign drop_abs  = drop_prod[35:`PU_SHIFT];
   assign lop_prod  = vn * `LOP_LEVEL_PU;
   assign lop_abs   = {4'h0, lop_prod[31:`PU_SHIFT]};

   // ==========================================================
   // Blocking of the undervoltage stage
   logic       under;
   logic       imin_block_r;
   logic [15:0] imin_cnt_r;
   logic       all_low;
   logic       lop_low;
   logic       blocked;

   assign under   = (mode == MODE_UNDER);
   assign all_low = (i_curr_1 < imin_thr_r) && (i_curr_2 < imin_thr_r)
                    && (i_curr_3 < imin_thr_r);
   assign lop_low = (v_sel[0] < lop_abs) || (v_sel[1] < lop_abs)
                    || (v_sel[2] < lop_abs);

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         imin_block_r <= 1'b0;
         imin_cnt_r   <= 16'h0;
      end else if (!(under && ctrl_r[`CTRL_IMIN_EN])) begin
         imin_block_r <= 1'b0;
         imin_cnt_r   <= 16'h0;
      end else if (all_low) begin
         imin_block_r <= 1'b1;
         imin_cnt_r   <= 16'h0;
      end else if (imin_block_r) begin
         if (imin_cnt_r >= imin_dly_r) imin_block_r <= 1'b0;
         else if (ms_tick) imin_cnt_r <= imin_cnt_r + 16'h1;
      end
   end

   assign blocked = !enable || (under && (imin_block_r
                    || ext_sync_r[1]
                    || (ctrl_r[`CTRL_SUPERV_EN] && fuse_sync_r[1])
                    || (ctrl_r[`CTRL_LOP_EN] && lop_low)));

   // ==========================================================
   // Per-phase pickup with dropout hysteresis
   // Input n feeds flag n; the connection only decides whether that input
   // carries a phase or a line-to-line voltage.
   logic [2:0] phase_pick_r;
   logic [1:0] pick_count;
   logic       elem_pick;

   always_ff @(posedge i_mclk) begin
      if (!i_rstn || blocked) begin
         phase_pick_r <= 3'h0;
      end else begin
         for (int p = 0; p < 3; p++) begin
            if (phase_pick_r[p])
               phase_pick_r[p] <= under ? (v_sel[p] < drop_abs) : (v_sel[p] > drop_abs);
            else
               phase_pick_r[p] <= under ? (v_sel[p] < thr_abs) : (v_sel[p] > thr_abs);
         end
      end
   end

   assign pick_count = 2'({1'b0, phase_pick_r[0]} + {1'b0, phase_pick_r[1]}
                       + {1'b0, phase_pick_r[2]});

   always_comb begin
      case (rule)
         RULE_ONE_OF_THREE: elem_pick = (pick_count >= 2'd1);
         RULE_TWO_OF_THREE: elem_pick = (pick_count >= 2'd2);
         RULE_ALL_THREE:    elem_pick = (pick_count == 2'd3);
         default:           elem_pick = (pick_count >= 2'd1);
      endcase
   end

   // ==========================================================
   // Trip delay
   logic [15:0] trip_cnt_r;
   logic        trip_r;

   always_ff @(posedge i_mclk) begin
      if (!i_rstn || !elem_pick || blocked) begin
         trip_cnt_r <= 16'h0;
         trip_r     <= 1'b0;
      end else if (trip_cnt_r >= trip_dly_r) begin
         trip_r <= 1'b1;
      end else if (ms_tick) begin
         trip_cnt_r <= trip_cnt_r + 16'h1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_phase_pickup_flag <= 3'h0;
         o_phase_trip_flag   <= 3'h0;
         o_pickup            <= 1'b0;
         o_trip              <= 1'b0;
      end else begin
         o_phase_pickup_flag <= elem_pick ? phase_pick_r : 3'h0;
         o_phase_trip_flag   <= trip_r ? phase_pick_r : 3'h0;
         o_pickup            <= elem_pick;
         o_trip              <= trip_r;
      end
   end

   // ==========================================================
   // Events and interrupt
   logic [2:0] ev_prev_r;
   logic [2:0] ev_now;
   logic [2:0] ev_rise;

   assign ev_now  = {blocked & enable, trip_r, elem_pick};
   assign ev_rise = ev_now & ~ev_prev_r;

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) ev_prev_r <= 3'h0;
      else ev_prev_r <= ev_now;
   end

   // ==========================================================
   // APB slave: one wait state, answer registered
   logic        acc_phase;
   logic        wr_en;
   logic        mapped;

   assign acc_phase = i_psel && i_penable && !o_pready;
   assign mapped    = (i_paddr[1:0] == 2'b00) && (i_paddr <= `REG_INT_MASK);
   assign wr_en     = acc_phase && i_pwrite && mapped;

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         ctrl_r     <= `CTRL_RST;
         thresh_r   <= `THRESH_RST;
         dropout_r  <= `DROPOUT_RST;
         trip_dly_r <= `TRIP_DLY_RST;
         imin_thr_r <= `IMIN_THR_RST;
         imin_dly_r <= `IMIN_DLY_RST;
         vt_sec_r   <= `VT_SEC_RST;
         int_mask_r <= 3'h0;
      end else if (wr_en) begin
         case (i_paddr)
            `REG_CTRL:     ctrl_r     <= i_pwdata[`CTRL_WIDTH-1:0];
            `REG_THRESH:   thresh_r   <= i_pwdata[15:0];
            `REG_DROPOUT:  dropout_r  <= i_pwdata[15:0];
            `REG_TRIP_DLY: trip_dly_r <= i_pwdata[15:0];
            `REG_IMIN_THR: imin_thr_r <= i_pwdata[15:0];
            `REG_IMIN_DLY: imin_dly_r <= i_pwdata[15:0];
            `REG_VT_SEC:   vt_sec_r   <= i_pwdata[15:0];
            `REG_INT_MASK: int_mask_r <= i_pwdata[2:0];
            default:       ;
         endcase
      end
   end

   // New events win over a write-one-to-clear in the same cycle
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         int_stat_r <= 3'h0;
      end else if (wr_en && i_paddr == `REG_INT_STAT) begin
         int_stat_r <= (int_stat_r & ~i_pwdata[2:0]) | ev_rise;
      end else begin
         int_stat_r <= int_stat_r | ev_rise;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) o_irq <= 1'b0;
      else o_irq <= |(int_stat_r & int_mask_r);
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0;
      end else begin
         o_pready  <= acc_phase;
         o_pslverr <= acc_phase && !mapped;
         o_prdata  <= 32'h0;
         if (acc_phase && !i_pwrite) begin
            case (i_paddr)
               `REG_CTRL:     o_prdata <= {21'h0, ctrl_r};
               `REG_THRESH:   o_prdata <= {16'h0, thresh_r};
               `REG_DROPOUT:  o_prdata <= {16'h0, dropout_r};
               `REG_TRIP_DLY: o_prdata <= {16'h0, trip_dly_r};
               `REG_IMIN_THR: o_prdata <= {16'h0, imin_thr_r};
               `REG_IMIN_DLY: o_prdata <= {16'h0, imin_dly_r};
               `REG_VT_SEC:   o_prdata <= {16'h0, vt_sec_r};
               `REG_STATUS:   o_prdata <= {23'h0, elem_pick, imin_block_r, blocked,
                                           trip_r ? phase_pick_r : 3'h0, phase_pick_r};
               `REG_INT_STAT: o_prdata <= {29'h0, int_stat_r};
               `REG_INT_MASK: o_prdata <= {29'h0, int_mask_r};
               default:       o_prdata <= 32'h0;
            endcase
         end
      end
   end

endmodule : voltage_protection_element
`default_nettype wire

// >>> test/meas_front_end.sv
// Model of the measurement front end: three voltage and three current magnitudes.
// Assumes the bench sets the targets; outputs follow on the next i_mclk edge.
`timescale 1ns/100ps
`default_nettype none
module meas_front_end #(
   parameter logic [15:0] HARM = 16'h0100
) (
   input  wire logic        i_mclk,
   input  wire logic [47:0] i_volt,
   input  wire logic [47:0] i_curr,
   output logic      [47:0] o_fund,
   output logic      [47:0] o_rms,
   output logic      [47:0] o_curr
);
   // ==========================================
   // Harmonic content lifts true RMS above the fundamental
   always_ff @(posedge i_mclk) begin
      for (int n = 0; n < 3; n++) begin
         o_fund[16*n +: 16] <= i_volt[16*n +: 16];
         o_rms[16*n +: 16]  <= i_volt[16*n +: 16] + HARM;
      end
      o_curr <= i_curr;
   end
endmodule : meas_front_end
`default_nettype wire

// >>> test/vprot_assertions.sv
// Port checker of the voltage protection element.
// Assumes a bind to voltage_protection_element; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module vprot_assertions (
   input wire logic        i_mclk,
   input wire logic        i_rstn,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic [2:0]  o_phase_pickup_flag,
   input wire logic [2:0]  o_phase_trip_flag,
   input wire logic        o_pickup,
   input wire logic        o_trip
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);
   // ==========================================
   // Register access
   a_ready_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("access not answered after one wait state");
   a_ready_pulse: assert property (o_pready |=> !o_pready)
      else $error("ready held longer than one cycle");
   a_err_reads_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
      else $error("error answer carries data");
   // ==========================================
   // Element outputs
   a_pick_has_phase: assert property (o_pickup |-> o_phase_pickup_flag != 3'h0)
      else $error("pickup without a phase flag");
   a_flag_needs_pick: assert property (o_phase_pickup_flag != 3'h0 |-> o_pickup)
      else $error("phase flag without element pickup");
   a_trip_after_pick: assert property ($rose(o_trip) |-> $past(o_pickup))
      else $error("trip without prior pickup");
   a_trip_drops: assert property ($fell(o_pickup) |-> ##[1:2] !o_trip)
      else $error("trip kept after dropout");
   a_trip_flags_idle: assert property (!o_trip [*3] |-> o_phase_trip_flag == 3'h0)
      else $error("trip flag while not tripped");
   c_trip: cover property ($rose(o_trip));
   c_error: cover property (o_pslverr);
   c_release: cover property ($fell(o_pickup));
endmodule : vprot_assertions
`default_nettype wire

// >>> test/voltage_protection_element_test.sv
// Self-checking bench of the voltage protection element over APB.
// Assumes the front end model and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "vprot_map.svh"
module voltage_protection_element_test;
   import vprot_pkg::*;
   localparam logic [31:0] CONN = 32'h20;
   localparam logic [31:0] MPP  = 32'h10;
   localparam logic [31:0] IMIN = 32'h100;
   localparam logic [31:0] SUPV = 32'h200;
   localparam logic [31:0] LOSS = 32'h400;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [47:0] volt = 48'h0;
   logic [47:0] curr = 48'h0;
   logic        ext_block = 1'b0;
   logic        fuse_fail = 1'b0;
   logic [31:0] prdata, rq;
   logic        pready, pslverr, pickup, trip, irq, re;
   logic [2:0]  pick_flag, trip_flag;
   logic [47:0] fund, rms, curr_m;
   logic [1:0]  mth [3] = '{2'h0, 2'h1, 2'h3};
   logic [31:0] mexp [3] = '{32'h0, 32'hF, 32'h0};
   logic [15:0] dv [4] = '{16'h1100, 16'h0FE0, 16'h0F00, 16'h0FE0};
   logic [31:0] dexp [4] = '{32'h9, 32'h9, 32'h0, 32'h0};
   int          num_errors = 0;
   int          check_count = 0;
   wire logic [31:0] pick_view = {28'h0, pickup, pick_flag};
   wire logic [31:0] trip_view = {28'h0, trip, trip_flag};

   always #25 mclk = ~mclk;

   meas_front_end fe (.i_mclk(mclk), .i_volt(volt), .i_curr(curr), .o_fund(fund),
      .o_rms(rms), .o_curr(curr_m));
   voltage_protection_element #(.MS_CYCLES(20), .AVG_SAMPLE_CYCLES(2)) uut (
      .i_mclk(mclk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr),
      .i_volt_fund_1(fund[15:0]), .i_volt_fund_2(fund[31:16]), .i_volt_fund_3(fund[47:32]),
      .i_volt_rms_1(rms[15:0]), .i_volt_rms_2(rms[31:16]), .i_volt_rms_3(rms[47:32]),
      .i_curr_1(curr_m[15:0]), .i_curr_2(curr_m[31:16]), .i_curr_3(curr_m[47:32]),
      .i_ext_block(ext_block), .i_vt_fuse_fail(fuse_fail), .o_phase_pickup_flag(pick_flag),
      .o_phase_trip_flag(trip_flag), .o_pickup(pickup), .o_trip(trip), .o_irq(irq));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // One transfer; request held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("ready wait", 32'(n >= 20), 32'h0);
   endtask : apb

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rq, exp);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   // Pin synchronisers and the pickup pipeline need a few edges
   task automatic setv(input logic [15:0] v1, v2, v3);
      @(posedge mclk);
      volt <= {v3, v2, v1};
      repeat (8) @(posedge mclk);
   endtask : setv

   function automatic logic [31:0] ctl(input logic u, input logic [1:0] m,
                                       input logic [1:0] r, input logic [31:0] x);
      return 32'h1 | {30'h0, u, 1'b0} | {28'h0, m, 2'h0} | {24'h0, r, 6'h0} | x;
   endfunction : ctl

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   initial begin
      #500000;
      chk("watchdog", 32'h1, 32'h0);
      results();
   end

   initial begin
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      // ==========================================
      // Reset values and an unmapped place
      rd("ctrl", `REG_CTRL, 32'h0);
      rd("thresh", `REG_THRESH, 32'h1000);
      rd("dropout", `REG_DROPOUT, 32'h0FC0);
      rd("trip delay", `REG_TRIP_DLY, 32'h64);
      rd("unmapped", 8'h28, 32'h0);
      chk("unmapped error", {31'h0, re}, 32'h1);
      $display("test registers done");
      // ==========================================
      // Nominal reference; ground reference is secondary over root 3
      wr(`REG_VT_SEC, 32'h1000);
      rd("secondary", `REG_VT_SEC, 32'h1000);
      wr(`REG_TRIP_DLY, 32'h0);
      wr(`REG_CTRL, ctl(1'b0, 2'h0, 2'h0, 32'h0));
      setv(16'h0A00, 16'h0, 16'h0);
      chk("ground reference", pick_view, 32'h9);
      chk("instant trip", trip_view, 32'h9);
      wr(`REG_CTRL, ctl(1'b0, 2'h0, 2'h0, MPP));
      repeat (8) @(posedge mclk);
      chk("phase reference", pick_view, 32'h0);
      wr(`REG_CTRL, ctl(1'b0, 2'h0, 2'h0, CONN));
      repeat (8) @(posedge mclk);
      chk("forced phase mode", pick_view, 32'h0);
      $display("test reference done");
      // ==========================================
      // Pickup rules and flag order
      setv(16'h0800, 16'h1100, 16'h1100);
      for (int r = 0; r < 4; r++) begin
         wr(`REG_CTRL, ctl(1'b0, 2'h0, 2'(r), CONN));
         repeat (8) @(posedge mclk);
         chk("pickup rule", pick_view, (r != 2) ? 32'hE : 32'h0);
      end
      setv(16'h1100, 16'h1100, 16'h1100);
      chk("all three", pick_view, 32'hF);
      $display("test rules done");
      // ==========================================
      // Measured quantity; the model's RMS sits above the fundamental
      setv(16'h0F80, 16'h0F80, 16'h0F80);
      for (int k = 0; k < 3; k++) begin
         wr(`REG_CTRL, ctl(1'b0, mth[k], 2'h0, CONN));
         repeat (8) @(posedge mclk);
         chk("method", pick_view, mexp[k]);
      end
      // Average starts from zeros and needs eight full segments of the new level
      wr(`REG_CTRL, ctl(1'b0, 2'h2, 2'h0, CONN));
      repeat (8) @(posedge mclk);
      chk("average lags", pick_view, 32'h0);
      repeat (4700) @(posedge mclk);
      chk("average settled", pick_view, 32'hF);
      wr(`REG_CTRL, ctl(1'b0, 2'h0, 2'h0, CONN));
      for (int k = 0; k < 4; k++) begin
         setv(dv[k], 16'h0, 16'h0);
         chk("dropout", pick_view, dexp[k]);
      end
      $display("test method and dropout done");
      // ==========================================
      // Trip delay
      wr(`REG_TRIP_DLY, 32'h2);
      setv(16'h1100, 16'h0, 16'h0);
      repeat (10) @(posedge mclk);
      chk("trip held off", trip_view, 32'h0);
      for (int n = 0; n < 100 && trip !== 1'b1; n++) @(posedge mclk);
      chk("delayed trip", trip_view, 32'h9);
      setv(16'h0, 16'h0, 16'h0);
      chk("trip cleared", trip_view, 32'h0);
      $display("test trip done");
      // ==========================================
      // Undervoltage and its blocking sources
      wr(`REG_DROPOUT, 32'h1040);
      wr(`REG_TRIP_DLY, 32'h1F);
      wr(`REG_IMIN_THR, 32'h100);
      wr(`REG_IMIN_DLY, 32'h3);
      curr <= {3{16'h0200}};
      wr(`REG_CTRL, ctl(1'b1, 2'h0, 2'h0, CONN | IMIN));
      setv(16'h0800, 16'h0800, 16'h0800);
      chk("undervoltage", pick_view, 32'hF);
      ext_block <= 1'b1;
      repeat (8) @(posedge mclk);
      chk("external block", pick_view, 32'h0);
      ext_block <= 1'b0;
      curr <= {3{16'h0050}};
      repeat (8) @(posedge mclk);
      chk("current block", pick_view, 32'h0);
      rd("block status", `REG_STATUS, 32'hC0);
      curr <= {16'h0050, 16'h0050, 16'h0200};
      repeat (8) @(posedge mclk);
      chk("release delay", pick_view, 32'h0);
      repeat (70) @(posedge mclk);
      chk("released", pick_view, 32'hF);
      fuse_fail <= 1'b1;
      repeat (8) @(posedge mclk);
      chk("fuse unsupervised", pick_view, 32'hF);
      wr(`REG_CTRL, ctl(1'b1, 2'h0, 2'h0, CONN | IMIN | SUPV));
      repeat (8) @(posedge mclk);
      chk("fuse failure", pick_view, 32'h0);
      fuse_fail <= 1'b0;
      wr(`REG_CTRL, ctl(1'b1, 2'h0, 2'h0, CONN | LOSS));
      setv(16'h0050, 16'h0050, 16'h0050);
      chk("potential loss", pick_view, 32'h0);
      setv(16'h0100, 16'h0100, 16'h0100);
      chk("potential present", pick_view, 32'hF);
      rd("status", `REG_STATUS, 32'h107);
      $display("test undervoltage done");
      // ==========================================
      // Interrupt status, mask and clear
      rd("event status", `REG_INT_STAT, 32'h7);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(`REG_INT_MASK, 32'h4);
      repeat (3) @(posedge mclk);
      chk("irq raised", {31'h0, irq}, 32'h1);
      wr(`REG_INT_STAT, 32'h7);
      rd("status cleared", `REG_INT_STAT, 32'h0);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      $display("test interrupts done");
      results();
   end
endmodule : voltage_protection_element_test

bind voltage_protection_element vprot_assertions chk_i (.i_mclk(i_mclk), .i_rstn(i_rstn),
   .i_psel(i_psel), .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .o_phase_pickup_flag(o_phase_pickup_flag),
   .o_phase_trip_flag(o_phase_trip_flag), .o_pickup(o_pickup), .o_trip(o_trip));
`default_nettype wire
